/* File: hdl/led_seq_pkg.sv */
package led_seq_pkg;

	localparam int unsigned CLK_HZ          = 100_000_000;
	// Timebase tick period, all phases are whole multiples of it.
	localparam int unsigned TICK_MS         = 250;
	localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned S3_PHASE_MS     = 250;
	localparam int unsigned READY_PHASE_MS  = 1000;
	localparam int unsigned UPD_PHASE_MS    = 500;
	localparam int unsigned MEM_PHASE_MS    = 1000;
	localparam int unsigned MEM_PAUSE_MS    = 2500;
	localparam int unsigned THERM_PHASE_MS  = 250;
	localparam int unsigned MEM_PAIRS       = 3;
	localparam int unsigned THERM_BLINKS    = 16;
	localparam int unsigned THERM_TOTAL_MS  = 8000;

	localparam logic [5:0] S3_TICKS    = 6'(S3_PHASE_MS / TICK_MS);
	localparam logic [5:0] READY_TICKS = 6'(READY_PHASE_MS / TICK_MS);
	localparam logic [5:0] UPD_TICKS   = 6'(UPD_PHASE_MS / TICK_MS);
	localparam logic [5:0] MEM_TICKS   = 6'(MEM_PHASE_MS / TICK_MS);
	localparam logic [5:0] PAUSE_TICKS = 6'(MEM_PAUSE_MS / TICK_MS);
	localparam logic [5:0] THERM_TICKS = 6'(THERM_PHASE_MS / TICK_MS);
	// Thermal burst: sixteen blinks over eight seconds means lit/dark pairs.
	localparam logic [5:0] THERM_PHASES = 6'(THERM_TOTAL_MS / THERM_PHASE_MS);
	localparam logic [5:0] MEM_PHASES   = 6'(2 * MEM_PAIRS);

	typedef enum logic [6:0] {
		PAT_OFF   = 7'h01,
		PAT_SOLID = 7'h02,
		PAT_S3    = 7'h04,
		PAT_READY = 7'h08,
		PAT_UPD   = 7'h10,
		PAT_MEM   = 7'h20,
		PAT_THERM = 7'h40
	} pattern_type;

	typedef struct packed {
		logic s0;
		logic s3;
		logic ready_mode;
		logic update;
		logic mem_error;
		logic thermal_trip;
		logic post_error;
	} sys_state_type;

	typedef struct packed {
		logic solid_enable;
		logic s3_alt_blink;
	} led_cfg_type;

endpackage

/* File: hdl/status_led_blink_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// RQ1: Working state lights primary colour steadily unless configuration disables it.
// RQ2: Standby blinks alternate colour, quarter second lit then dark, endlessly.
// RQ3: Configuration may replace the standby blink with another behaviour.
// RQ4: Low-power ready state blinks primary one second lit, one second dark.
// RQ5: Update starts dark, then half second primary lit/dark until finished.
// RQ6: Memory error: three one-second pairs, 2.5 s dark, repeat until reset.
// RQ7: Thermal trip blinks quarter-second phases, stopping after sixteen blinks over eight seconds.
// RQ8: Self-test error codes override the normal state indication.
// RQ9: Clock-derived timebase; errors over states; new pattern restarts at phase one.
module status_led_blink_sequencer #(
	parameter int unsigned TICK_CYCLES = led_seq_pkg::TICK_CYCLES
) (
	input  wire logic                       clk_i,
	input  wire logic                       rstn_i,
	input  wire led_seq_pkg::sys_state_type state_i,
	input  wire led_seq_pkg::led_cfg_type   cfg_i,
	output logic                            primary_o,
	output logic                            alternate_o,
	output logic                            therm_done_o
);

	logic [31:0]              div;
	logic [31:0]              next_div;
	logic                     tick;
	logic                     next_tick;
	led_seq_pkg::pattern_type pat;
	led_seq_pkg::pattern_type next_pat;
	led_seq_pkg::pattern_type want;
	logic [5:0]               ticks;
	logic [5:0]               next_ticks;
	logic [5:0]               phase;
	logic [5:0]               next_phase;
	logic                     mem_latch;
	logic                     next_mem_latch;
	logic                     therm_done;
	logic                     next_therm_done;
	logic                     next_primary;
	logic                     next_alternate;

	function automatic logic [5:0] phase_len(input led_seq_pkg::pattern_type p,
		input logic [5:0] ph);
		unique case (p)
			led_seq_pkg::PAT_S3:    phase_len = led_seq_pkg::S3_TICKS;
			led_seq_pkg::PAT_READY: phase_len = led_seq_pkg::READY_TICKS;
			led_seq_pkg::PAT_UPD:   phase_len = led_seq_pkg::UPD_TICKS;
			led_seq_pkg::PAT_MEM:   phase_len = (ph == led_seq_pkg::MEM_PHASES) ?
				led_seq_pkg::PAUSE_TICKS : led_seq_pkg::MEM_TICKS;
			led_seq_pkg::PAT_THERM: phase_len = led_seq_pkg::THERM_TICKS;
			default:                phase_len = 6'h01;
		endcase
	endfunction

	// The divider runs free and is not restarted on a pattern change, so a new
	// pattern's first phase may be up to one tick short; one divider serves all.
	// RQ9 derived timebase
	always_comb begin
		next_tick = 1'b0;
		next_div = div + 32'h1;
		if (div >= TICK_CYCLES - 1) begin
			next_div = 32'h0;
			next_tick = 1'b1;
		end
	end

	// RQ9 error priority
	// RQ8 self-test override
	always_comb begin
		want = led_seq_pkg::PAT_OFF;
		if (mem_latch || state_i.mem_error || state_i.post_error) begin
			want = led_seq_pkg::PAT_MEM;
		end else if (state_i.thermal_trip && !therm_done) begin
			want = led_seq_pkg::PAT_THERM;
		end else if (state_i.update) begin
			want = led_seq_pkg::PAT_UPD;
		end else if (state_i.ready_mode) begin
			want = led_seq_pkg::PAT_READY;
		end else if (state_i.s3) begin
			// RQ3 standby override
			want = cfg_i.s3_alt_blink ? led_seq_pkg::PAT_S3 : led_seq_pkg::PAT_OFF;
		end else if (state_i.s0 && cfg_i.solid_enable) begin
			// RQ1 steady working
			want = led_seq_pkg::PAT_SOLID;
		end
	end

	always_comb begin
		next_pat = want;
		next_ticks = ticks;
		next_phase = phase;
		next_mem_latch = mem_latch | state_i.mem_error;
		next_therm_done = therm_done;
		if (!state_i.thermal_trip) begin
			next_therm_done = 1'b0;
		end
		if (want != pat) begin
			// RQ9 restart phase
			next_ticks = 6'h0;
			next_phase = 6'h0;
		end else if (tick) begin
			if (ticks + 6'h1 >= phase_len(pat, phase)) begin
				next_ticks = 6'h0;
				next_phase = phase + 6'h1;
				// RQ6 pause repeat
				if (pat == led_seq_pkg::PAT_MEM && phase == led_seq_pkg::MEM_PHASES) begin
					next_phase = 6'h0;
				end
				if (pat != led_seq_pkg::PAT_MEM && phase[0]) begin
					next_phase = 6'h0;
				end
				// RQ7 burst end
				if (pat == led_seq_pkg::PAT_THERM &&
					phase == led_seq_pkg::THERM_PHASES - 6'h1) begin
					next_therm_done = 1'b1;
					next_phase = 6'h0;
				end
				if (pat == led_seq_pkg::PAT_THERM && phase != led_seq_pkg::THERM_PHASES - 6'h1) begin
					next_phase = phase + 6'h1;
				end
			end else begin
				next_ticks = ticks + 6'h1;
			end
		end
	end

	always_comb begin
		next_primary = 1'b0;
		next_alternate = 1'b0;
		unique case (next_pat)
			led_seq_pkg::PAT_OFF:   next_primary = 1'b0;
			led_seq_pkg::PAT_SOLID: next_primary = 1'b1;
			// RQ2 standby blink
			led_seq_pkg::PAT_S3:    next_alternate = ~next_phase[0];
			// RQ4 ready blink
			led_seq_pkg::PAT_READY: next_primary = ~next_phase[0];
			// RQ5 update dark first
			led_seq_pkg::PAT_UPD:   next_primary = next_phase[0];
			// RQ6 memory code
			led_seq_pkg::PAT_MEM:   next_primary = ~next_phase[0] &&
				(next_phase < led_seq_pkg::MEM_PHASES);
			// The done flag keeps the lamp dark in the cycle before the burst is dropped.
			// RQ7 dark after burst
			led_seq_pkg::PAT_THERM: next_primary = ~next_phase[0] && !next_therm_done;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div <= 32'h0;
			tick <= 1'b0;
			pat <= led_seq_pkg::PAT_OFF;
			ticks <= 6'h0;
			phase <= 6'h0;
			mem_latch <= 1'b0;
			therm_done <= 1'b0;
			primary_o <= 1'b0;
			alternate_o <= 1'b0;
			therm_done_o <= 1'b0;
		end else begin
			div <= next_div;
			tick <= next_tick;
			pat <= next_pat;
			ticks <= next_ticks;
			phase <= next_phase;
			mem_latch <= next_mem_latch;
			therm_done <= next_therm_done;
			primary_o <= next_primary;
			alternate_o <= next_alternate;
			therm_done_o <= next_therm_done;
		end
	end

	mem_sticky_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ6
		mem_latch |=> pat == led_seq_pkg::PAT_MEM)
		else $error("memory pattern left while error latched");
	solid_on_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ1
		pat == led_seq_pkg::PAT_SOLID && $stable(pat) |-> primary_o)
		else $error("solid pattern not lit");
	s3_colour_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ2
		pat == led_seq_pkg::PAT_S3 |-> !primary_o)
		else $error("standby used primary colour");
	s3_cfg_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ3
		pat == led_seq_pkg::PAT_S3 |-> $past(cfg_i.s3_alt_blink))
		else $error("standby blink while disabled");
	ready_mono_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ4
		pat == led_seq_pkg::PAT_READY |-> !alternate_o)
		else $error("ready used alternate colour");
	upd_dark_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ5
		$changed(pat) && pat == led_seq_pkg::PAT_UPD |-> !primary_o)
		else $error("update did not start dark");
	therm_len_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ7
		pat == led_seq_pkg::PAT_THERM |-> phase < led_seq_pkg::THERM_PHASES)
		else $error("thermal burst overran");
	restart_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ9
		$changed(pat) |-> phase == 6'h0 && ticks == 6'h0)
		else $error("new pattern did not restart");
	post_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ8
		state_i.post_error |=> pat == led_seq_pkg::PAT_MEM)
		else $error("self-test error not shown");
	therm_dark_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ7
		pat == led_seq_pkg::PAT_THERM && therm_done |-> !primary_o)
		else $error("lamp lit after thermal burst ended");
	therm_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ7
		therm_done && state_i.thermal_trip |=> therm_done)
		else $error("thermal burst rearmed while trip still high");
	mem_pause_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ6
		pat == led_seq_pkg::PAT_MEM && phase == led_seq_pkg::MEM_PHASES |-> !primary_o)
		else $error("memory pause not dark");
	upd_prio_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ9
		state_i.update && !state_i.mem_error && !state_i.post_error && !mem_latch &&
		!(state_i.thermal_trip && !therm_done) |=> pat == led_seq_pkg::PAT_UPD)
		else $error("update did not take priority over states");

	mem_c: cover property (@(posedge clk_i) pat == led_seq_pkg::PAT_MEM && phase == 6'h6);
	therm_c: cover property (@(posedge clk_i) therm_done);
	s3_c: cover property (@(posedge clk_i) alternate_o);
	ready_c: cover property (@(posedge clk_i) pat == led_seq_pkg::PAT_READY && phase == 6'h1);
	upd_c: cover property (@(posedge clk_i) pat == led_seq_pkg::PAT_UPD && primary_o);

endmodule
`default_nettype wire

/* File: tb/led_lamp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module led_lamp_model (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       lit_i,
	output logic [7:0]      on_len_o,
	output logic [7:0]      off_len_o,
	output logic [7:0]      blinks_o
);
	logic [7:0] run;
	logic       last;

	// A lamp only shows a level, so it reports finished run lengths and flashes seen.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run       <= 8'h01;
			last      <= 1'b0;
			on_len_o  <= 8'h00;
			off_len_o <= 8'h00;
			blinks_o  <= 8'h00;
		end else if (lit_i == last) begin
			run <= run + 8'h01;
		end else begin
			run  <= 8'h01;
			last <= lit_i;
			if (last) begin
				on_len_o <= run;
			end else begin
				off_len_o <= run;
				blinks_o  <= blinks_o + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/status_led_blink_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module status_led_blink_sequencer_tb;
	localparam int TC = 4;
	logic                       clk_i  = 1'b0;
	logic                       rstn_i = 1'b0;
	led_seq_pkg::sys_state_type st     = '0;
	led_seq_pkg::led_cfg_type   cfg    = '0;
	logic                       pri;
	logic                       alt;
	logic                       tdone;
	logic [7:0]                 pon, poff, pbl, aon, aoff, abl, b0, a0;
	int                         n_mismatch = 0;
	int                         n_checks   = 0;
	int                         cycles     = 0;

	status_led_blink_sequencer #(.TICK_CYCLES(TC)) i_status_led_blink_sequencer (
		.clk_i(clk_i), .rstn_i(rstn_i), .state_i(st), .cfg_i(cfg),
		.primary_o(pri), .alternate_o(alt), .therm_done_o(tdone));
	led_lamp_model i_led_lamp_model (.clk_i(clk_i), .rstn_i(rstn_i), .lit_i(pri),
		.on_len_o(pon), .off_len_o(poff), .blinks_o(pbl));
	led_lamp_model i_led_lamp_model_alt (.clk_i(clk_i), .rstn_i(rstn_i), .lit_i(alt),
		.on_len_o(aon), .off_len_o(aoff), .blinks_o(abl));

	always #5 clk_i = ~clk_i;

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// The whole sequence needs well under a thousand cycles.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic go(input logic [6:0] s, input logic [1:0] c);
		@(posedge clk_i);
		st  <= s;
		cfg <= c;
	endtask

	task automatic do_reset;
		@(posedge clk_i);
		rstn_i <= 1'b0;
		st     <= '0;
		cyc(8);
		rstn_i <= 1'b1;
	endtask

	task automatic t_solid;
		go(7'h40, 2'h2);
		cyc(2);
		chk("primary", 32'(pri), 32'h1);
		chk("alternate", 32'(alt), 32'h0);
		go(7'h40, 2'h0);
		cyc(2);
		chk("primary", 32'(pri), 32'h0);
		$display("solid done");
	endtask

	task automatic t_s3;
		go(7'h20, 2'h1);
		cyc(6 * TC);
		chk("alt on", 32'(aon), 32'(TC));
		chk("alt off", 32'(aoff), 32'(TC));
		chk("primary", 32'(pri), 32'h0);
		b0 = abl;
		go(7'h20, 2'h0);
		cyc(6 * TC);
		chk("alt flashes", 32'(abl), 32'(b0));
		$display("standby done");
	endtask

	task automatic t_ready_upd;
		go(7'h10, 2'h2);
		cyc(14 * TC);
		chk("ready on", 32'(pon), 32'(4 * TC));
		chk("ready off", 32'(poff), 32'(4 * TC));
		go(7'h18, 2'h2);
		cyc(2);
		chk("update start", 32'(pri), 32'h0);
		cyc(12 * TC);
		chk("update on", 32'(pon), 32'(2 * TC));
		chk("update off", 32'(poff), 32'(2 * TC));
		$display("ready update done");
	endtask

	task automatic t_therm;
		do_reset();
		go(7'h02, 2'h0);
		cyc(16 * TC);
		chk("therm early", 32'(tdone), 32'h0);
		cyc(16 * TC + 8);
		chk("therm flashes", 32'(pbl), 32'h10);
		chk("therm done", 32'(tdone), 32'h1);
		cyc(10 * TC);
		chk("therm flashes", 32'(pbl), 32'h10);
		$display("thermal done");
	endtask

	task automatic t_post;
		do_reset();
		go(7'h41, 2'h2);
		cyc(15 * TC);
		chk("post on", 32'(pon), 32'(4 * TC));
		go(7'h40, 2'h2);
		cyc(2);
		chk("post released", 32'(pri), 32'h1);
		$display("self test done");
	endtask

	task automatic t_mem;
		go(7'h64, 2'h3);
		cyc(2);
		go(7'h60, 2'h3);
		cyc(10 * TC);
		b0 = pbl;
		a0 = abl;
		cyc(34 * TC);
		chk("mem flashes", 32'(8'(pbl - b0)), 32'h3);
		chk("mem on", 32'(pon), 32'(4 * TC));
		chk("alt flashes", 32'(abl), 32'(a0));
		$display("memory done");
	endtask

	initial begin
		cyc(8);
		rstn_i <= 1'b1;
		t_solid();
		t_s3();
		t_ready_upd();
		t_therm();
		t_post();
		t_mem();
		finish_test();
	end
endmodule
`default_nettype wire
